// ---- access_guard_pkg.sv ----
/*
  Shared constants and carriers for the PMBus access guard:
  command codes, write-protect levels, lock-key status codes, request/answer structs.
  Assumes the PMBus protocol engine frames transactions and presents them as requests.
*/
package access_guard_pkg;

  // command codes seen by the guard
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_ON_OFF_CONFIG = 8'h02;
  localparam logic [7:0] CMD_INDIRECT_PHASE_READ = 8'h0A;
  localparam logic [7:0] CMD_NVM_LOCK_KEY = 8'h0E;
  localparam logic [7:0] CMD_WRITE_GUARD_LEVEL = 8'h10;
  localparam logic [7:0] CMD_STORE_USER = 8'h15;
  localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
  localparam logic [7:0] CMD_VOUT_COMMAND = 8'h21;
  // value arbitrary; set to the extended guard's real code at integration
  localparam logic [7:0] CMD_EXTENDED_WRITE_GUARD = 8'hF0;

  // indirect read field layout
  localparam int TGT_CMD_LSB = 16;
  localparam int TGT_PHASE_LSB = 8;
  localparam int TGT_PAGE_LSB = 0;
  localparam logic [7:0] PAGE_ZERO = 8'h00;
  localparam logic [7:0] ALL_SEL = 8'hFF;
  localparam logic [23:0] INDIRECT_RESET = 24'h000000;

  // write guard levels
  localparam logic [7:0] WG_OPEN = 8'h00;
  localparam logic [7:0] WG_CTRL = 8'h20;
  localparam logic [7:0] WG_OP = 8'h40;
  localparam logic [7:0] WG_STORE = 8'h80;
  localparam logic [7:0] WG_VOUT_HARD = 8'h02;
  localparam logic [7:0] WG_ALL_HARD = 8'h03;

  // lock key
  localparam logic [31:0] KEY_ZERO = 32'h00000000;
  localparam logic [1:0] ATTEMPT_LIMIT = 2'h3;
  localparam logic [7:0] KEY_STAT_0 = 8'h10;
  localparam logic [7:0] KEY_STAT_1 = 8'h11;
  localparam logic [7:0] KEY_STAT_2 = 8'h12;
  localparam logic [7:0] KEY_STAT_MAX = 8'h1F;
  localparam logic [2:0] KEY_READ_BYTES = 3'h3;
  localparam int NVM_STORE_LOCK_BIT = 0;

  typedef enum logic [1:0]
  {
    KIND_WRITE = 2'b00,
    KIND_READ = 2'b01,
    KIND_CALL = 2'b10,
    KIND_SEND = 2'b11
  } req_kind_e;

  typedef struct packed
  {
    req_kind_e kind;
    logic [7:0] code;
    logic [3:0] count;
    logic [31:0] data;
  } req_s;

  typedef struct packed
  {
    logic ack;
    logic [2:0] count;
    logic [31:0] data;
  } resp_s;

endpackage

// ---- pmbus_access_guard.sv ----
/*
  Command-level access guard: indirect phased read, lock key with attempt counter,
  write guard level. Requests arrive from the PMBus engine on the link side with a
  toggle; request data is held stable from the toggle until the answer toggle returns.
*/
`timescale 1ns/100ps
module pmbus_access_guard
  import access_guard_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic req_toggle_in,
  input wire req_s req_in,
  input wire logic [1:0] stack_position_in,
  input wire logic primary_in,
  input wire logic [31:0] nvm_key_in,
  input wire logic [7:0] nvm_guard_level_in,
  input wire logic [7:0] extended_write_guard_in,
  input wire logic [31:0] target_data_in,
  input wire logic [2:0] target_count_in,
  input wire logic target_valid_in,
  output logic resp_toggle_out,
  output resp_s resp_out,
  output logic target_read_out,
  output logic [7:0] target_command_code_out,
  output logic [7:0] target_phase_number_out,
  output logic [7:0] target_page_number_out,
  output logic write_pass_out,
  output logic store_go_out,
  output logic [31:0] key_to_store_out,
  output logic [7:0] write_guard_level_out,
  output logic invalid_command_out,
  output logic invalid_data_out,
  output logic alert_out
);

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_TARGET = 2'b10,
    ST_ANSWER = 2'b11
  } state_e;

  state_e state_reg;
  logic tog_meta_reg, tog_sync_reg, tog_seen_reg;
  req_s cur_reg;
  resp_s resp_reg;
  logic resp_toggle_reg;
  logic [31:0] key_reg, active_key_reg;
  logic key_written_reg, unlocked_reg, boot_reg;
  logic [1:0] attempt_reg;
  logic [7:0] level_reg;
  logic [23:0] indirect_reg;
  logic tgt_read_reg, pass_reg, store_reg, ivc_reg, ivd_reg;

  logic new_req, locked, page_ok, phase_ok, key_match;
  logic [7:0] req_page, req_phase;

  // allowed write targets per guard level; unlisted levels (WG_ALL_HARD) allow no write
  function automatic logic level_allows(input logic [7:0] lvl, input logic [7:0] code);
    logic guard_or_store;
    guard_or_store = (code == CMD_WRITE_GUARD_LEVEL) || (code == CMD_STORE_USER);
    unique case (lvl)
      WG_OPEN: level_allows = 1'b1;
      WG_CTRL: level_allows = guard_or_store || code == CMD_OPERATION
                              || code == CMD_ON_OFF_CONFIG || code == CMD_VOUT_COMMAND;
      WG_OP: level_allows = guard_or_store || code == CMD_OPERATION;
      WG_STORE: level_allows = guard_or_store;
      WG_VOUT_HARD: level_allows = (code == CMD_VOUT_COMMAND);
      default: level_allows = 1'b0;
    endcase
  endfunction

  function automatic logic level_valid(input logic [7:0] lvl);
    level_valid = lvl == WG_OPEN || lvl == WG_CTRL || lvl == WG_OP || lvl == WG_STORE
                  || lvl == WG_VOUT_HARD || lvl == WG_ALL_HARD;
  endfunction

  function automatic logic tgt_read_next();
    tgt_read_next = cur_reg.kind == KIND_CALL && cur_reg.code == CMD_INDIRECT_PHASE_READ
                    && page_ok && phase_ok;
  endfunction

  // the link side holds req_in steady while its toggle is unanswered
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      tog_meta_reg <= 1'b0;
      tog_sync_reg <= 1'b0;
      tog_seen_reg <= 1'b0;
    end
    else
    begin
      tog_meta_reg <= req_toggle_in;
      tog_sync_reg <= tog_meta_reg;
      if (state_reg == ST_IDLE)
        tog_seen_reg <= tog_sync_reg;
    end
  end

  assign new_req = (state_reg == ST_IDLE) && (tog_sync_reg != tog_seen_reg);
  assign req_page = cur_reg.data[TGT_PAGE_LSB +: 8];
  assign req_phase = cur_reg.data[TGT_PHASE_LSB +: 8];
  assign page_ok = (req_page == PAGE_ZERO) || (req_page == ALL_SEL);
  assign phase_ok = (req_phase == {6'h00, stack_position_in}) || (req_phase == ALL_SEL);
  assign locked = (active_key_reg != KEY_ZERO) && !unlocked_reg;
  assign key_match = (cur_reg.data == active_key_reg);

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      state_reg <= ST_IDLE;
    else
    begin
      unique case (state_reg)
        ST_IDLE: state_reg <= new_req ? ST_EXEC : ST_IDLE;
        ST_EXEC: state_reg <= tgt_read_next() ? ST_TARGET : ST_ANSWER;
        ST_TARGET: state_reg <= target_valid_in ? ST_ANSWER : ST_TARGET;
        ST_ANSWER: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      cur_reg <= '0;
    else if (new_req)
      cur_reg <= req_in;
  end

  // indirect read: forwards selections without writing the live page/phase
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      indirect_reg <= INDIRECT_RESET;
      tgt_read_reg <= 1'b0;
      ivc_reg <= 1'b0;
    end
    else
    begin
      tgt_read_reg <= 1'b0;
      ivc_reg <= 1'b0;
      if (state_reg == ST_EXEC && cur_reg.kind == KIND_CALL
          && cur_reg.code == CMD_INDIRECT_PHASE_READ)
      begin
        indirect_reg <= cur_reg.data[23:0];
        tgt_read_reg <= page_ok && phase_ok;
        ivc_reg <= !(page_ok && phase_ok) && primary_in;
      end
    end
  end

  // lock key; boot_reg loads the active key once after reset release
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      key_reg <= KEY_ZERO;
      active_key_reg <= KEY_ZERO;
      key_written_reg <= 1'b0;
      unlocked_reg <= 1'b0;
      attempt_reg <= 2'h0;
      boot_reg <= 1'b1;
    end
    else
    begin
      boot_reg <= 1'b0;
      if (boot_reg || (state_reg == ST_EXEC && cur_reg.kind == KIND_SEND
                       && cur_reg.code == CMD_RESTORE_USER))
      begin
        active_key_reg <= nvm_key_in;
        key_reg <= nvm_key_in;
        key_written_reg <= (nvm_key_in != KEY_ZERO);
        unlocked_reg <= 1'b0;
      end
      else if (state_reg == ST_EXEC && cur_reg.kind == KIND_WRITE
               && cur_reg.code == CMD_NVM_LOCK_KEY && attempt_reg != ATTEMPT_LIMIT)
      begin
        if (!locked)
        begin
          key_reg <= cur_reg.data;
          key_written_reg <= 1'b1;
        end
        else if (key_match)
        begin
          unlocked_reg <= 1'b1;
          attempt_reg <= 2'h0;
        end
        else
          attempt_reg <= attempt_reg + 2'h1;
      end
    end
  end

  // write guard level: loaded from store at boot, hard levels stick until rstn_in reset
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      level_reg <= WG_OPEN;
    else if (boot_reg)
      level_reg <= level_valid(nvm_guard_level_in) ? nvm_guard_level_in : WG_OPEN;
    else if (state_reg == ST_EXEC && cur_reg.kind == KIND_WRITE
             && cur_reg.code == CMD_WRITE_GUARD_LEVEL
             && level_allows(level_reg, CMD_WRITE_GUARD_LEVEL)
             && level_valid(cur_reg.data[7:0]))
      level_reg <= cur_reg.data[7:0];
  end

  // write decisions and answer
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pass_reg <= 1'b0;
      store_reg <= 1'b0;
      ivd_reg <= 1'b0;
      resp_reg <= '0;
      resp_toggle_reg <= 1'b0;
    end
    else
    begin
      pass_reg <= 1'b0;
      store_reg <= 1'b0;
      ivd_reg <= 1'b0;
      if (state_reg == ST_EXEC)
      begin
        resp_reg <= '{ack: 1'b1, count: 3'h1, data: KEY_ZERO};
        if (cur_reg.kind == KIND_READ)
        begin
          if (cur_reg.code == CMD_NVM_LOCK_KEY)
          begin
            resp_reg.count <= KEY_READ_BYTES;
            if (!locked)
              resp_reg.data <= key_written_reg ? {8'h00, key_reg[23:0]} : KEY_ZERO;
            else
              resp_reg.data <= {24'h000000, attempt_reg == 2'h0 ? KEY_STAT_0 :
                                attempt_reg == 2'h1 ? KEY_STAT_1 :
                                attempt_reg == 2'h2 ? KEY_STAT_2 : KEY_STAT_MAX};
          end
          else if (cur_reg.code == CMD_WRITE_GUARD_LEVEL)
            resp_reg.data <= {24'h000000, level_reg};
        end
        else if (cur_reg.kind == KIND_CALL)
          resp_reg.ack <= tgt_read_next();
        else if (cur_reg.code == CMD_NVM_LOCK_KEY)
        begin
          // byte count is not checked: short and long writes are acknowledged
          resp_reg.ack <= (attempt_reg != ATTEMPT_LIMIT);
          ivd_reg <= (attempt_reg == ATTEMPT_LIMIT);
        end
        else if (cur_reg.code == CMD_EXTENDED_WRITE_GUARD
                 && (locked || !level_allows(level_reg, cur_reg.code)))
        begin
          resp_reg.ack <= 1'b0;
          ivd_reg <= 1'b1;
        end
        else if (cur_reg.code == CMD_STORE_USER)
        begin
          if ((locked && extended_write_guard_in[NVM_STORE_LOCK_BIT])
              || !level_allows(level_reg, cur_reg.code))
          begin
            resp_reg.ack <= 1'b0;
            ivd_reg <= 1'b1;
          end
          else
            store_reg <= 1'b1;
        end
        else if (cur_reg.code == CMD_WRITE_GUARD_LEVEL && !level_valid(cur_reg.data[7:0]))
        begin
          resp_reg.ack <= 1'b0;
          ivd_reg <= 1'b1;
        end
        else if (level_allows(level_reg, cur_reg.code))
          pass_reg <= (cur_reg.code != CMD_WRITE_GUARD_LEVEL) && (cur_reg.code != CMD_RESTORE_USER);
        else
        begin
          resp_reg.ack <= 1'b0;
          ivd_reg <= 1'b1;
        end
      end
      else if (state_reg == ST_TARGET && target_valid_in)
      begin
        resp_reg.data <= target_data_in;
        resp_reg.count <= target_count_in;
      end
      if (state_reg == ST_ANSWER)
        resp_toggle_reg <= ~resp_toggle_reg;
    end
  end

  assign resp_toggle_out = resp_toggle_reg;
  assign resp_out = resp_reg;
  assign target_read_out = tgt_read_reg;
  assign target_command_code_out = indirect_reg[TGT_CMD_LSB +: 8];
  assign target_phase_number_out = indirect_reg[TGT_PHASE_LSB +: 8];
  assign target_page_number_out = indirect_reg[TGT_PAGE_LSB +: 8];
  assign write_pass_out = pass_reg;
  assign store_go_out = store_reg;
  assign key_to_store_out = key_reg;
  assign write_guard_level_out = level_reg;
  assign invalid_command_out = ivc_reg;
  assign invalid_data_out = ivd_reg;
  assign alert_out = ivc_reg | ivd_reg;

  a_bad_page_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
    state_reg == ST_EXEC && cur_reg.kind == KIND_CALL && cur_reg.code == CMD_INDIRECT_PHASE_READ
    && !page_ok && primary_in |=> invalid_command_out && alert_out && !target_read_out)
    else $error("bad page not flagged");
  a_phase_check: assert property (@(posedge clk_in) disable iff (!rstn_in)
    target_read_out |-> (target_phase_number_out == ALL_SEL
    || target_phase_number_out == {6'h00, stack_position_in}))
    else $error("target read with foreign phase");
  a_page_accept: assert property (@(posedge clk_in) disable iff (!rstn_in)
    target_read_out |-> (target_page_number_out == PAGE_ZERO
    || target_page_number_out == ALL_SEL))
    else $error("target read with bad page");
  a_key_read_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
    state_reg == ST_EXEC && cur_reg.kind == KIND_READ && cur_reg.code == CMD_NVM_LOCK_KEY
    && !locked && !key_written_reg |=> resp_out.data == KEY_ZERO && resp_out.count == 3'h3)
    else $error("unwritten key not read as zero");
  a_key_status_max: assert property (@(posedge clk_in) disable iff (!rstn_in)
    state_reg == ST_EXEC && cur_reg.kind == KIND_READ && cur_reg.code == CMD_NVM_LOCK_KEY
    && locked && attempt_reg == 2'h3 |=> resp_out.data[7:0] == 8'h1F)
    else $error("locked status code wrong");
  a_attempt_refuse: assert property (@(posedge clk_in) disable iff (!rstn_in)
    state_reg == ST_EXEC && cur_reg.kind == KIND_WRITE && cur_reg.code == CMD_NVM_LOCK_KEY
    && attempt_reg == 2'h3 |=> !resp_out.ack && invalid_data_out && $stable(key_reg))
    else $error("key write after limit accepted");
  a_attempt_count: assert property (@(posedge clk_in) disable iff (!rstn_in)
    state_reg == ST_EXEC && cur_reg.kind == KIND_WRITE && cur_reg.code == CMD_NVM_LOCK_KEY
    && locked && !key_match && attempt_reg != 2'h3 |=> attempt_reg == $past(attempt_reg) + 2'h1)
    else $error("attempt counter not bumped");
  a_store_locked: assert property (@(posedge clk_in) disable iff (!rstn_in)
    locked && extended_write_guard_in[0] && state_reg == ST_EXEC && cur_reg.code == CMD_STORE_USER
    |=> !store_go_out && invalid_data_out)
    else $error("store passed under lock");
  a_hard_level_holds: assert property (@(posedge clk_in) disable iff (!rstn_in)
    level_reg == WG_ALL_HARD && !boot_reg |=> level_reg == WG_ALL_HARD && !write_pass_out)
    else $error("hard write guard released");

endmodule // pmbus_access_guard

// ---- pmbus_host_model.sv ----
/*
  Host-side model: turns each change of go_in into one toggle request and
  holds it until the guard's answer toggle is seen on the link clock.
  Assumes the bench sets cmd_in before flipping go_in.
*/
`timescale 1ns/100ps
module pmbus_host_model
  import access_guard_pkg::*;
(
  input wire logic link_clk_in,
  input wire logic rstn_in,
  input wire logic go_in,
  input wire req_s cmd_in,
  input wire logic resp_toggle_in,
  output logic req_toggle_out,
  output req_s req_out,
  output logic done_out
);
  logic go_seen_reg;
  logic resp_seen_reg;
  logic busy_reg;

  always @(posedge link_clk_in or negedge rstn_in)
  begin
    #2;
    if (!rstn_in)
    begin
      go_seen_reg = go_in;
      resp_seen_reg = 1'b0;
      busy_reg = 1'b0;
      req_toggle_out = 1'b0;
      req_out = '0;
      done_out = 1'b1;
    end
    else if (busy_reg && resp_toggle_in !== resp_seen_reg)
    begin
      resp_seen_reg = resp_toggle_in;
      busy_reg = 1'b0;
      // released: never leave the old request readable
      req_out = ~req_out;
      done_out = 1'b1;
    end
    else if (!busy_reg && go_in !== go_seen_reg)
    begin
      go_seen_reg = go_in;
      req_out = cmd_in;
      req_toggle_out = ~req_toggle_out;
      busy_reg = 1'b1;
      done_out = 1'b0;
    end
  end
endmodule // pmbus_host_model

// ---- pmbus_access_guard_test.sv ----
/*
  Self-checking bench for the access guard: indirect read, guard levels, lock key.
  Assumes pmbus_host_model as the requesting side and a bench-side register core.
*/
`timescale 1ns/100ps
`define CHECK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
  end
module pmbus_access_guard_test
  import access_guard_pkg::*;
;
  localparam logic [35:0] M_ACK = 36'h800000000;
  localparam logic [35:0] M_ALL = 36'hFFFFFFFFF;
  localparam logic [35:0] M_B3 = 36'hF00FFFFFF;
  // ack with a three-byte count; the count only matters where a mask keeps it
  localparam logic [35:0] A1 = 36'hB00000000;
  logic clk_in, rstn_in, link_clk, go, done, trd, resp_last, req_toggle_in, target_valid_in;
  logic primary_in, resp_toggle_out, target_read_out, write_pass_out, store_go_out;
  logic invalid_command_out, invalid_data_out, alert_out;
  req_s cmd, req_in;
  resp_s resp_out;
  logic [1:0] stack_position_in;
  logic [2:0] target_count_in;
  logic [7:0] nvm_guard_level_in, extended_write_guard_in, write_guard_level_out;
  logic [7:0] target_command_code_out, target_phase_number_out, target_page_number_out;
  logic [23:0] tfields;
  logic [31:0] nvm_key_in, target_data_in, key_to_store_out, seed, key;
  logic [35:0] exp_q[$], msk_q[$], em, mk;
  int failures, samples_checked, n_ic, n_id, n_al, n_wp, n_sg, n_tr;

  pmbus_access_guard u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .req_toggle_in(req_toggle_in),
    .req_in(req_in), .stack_position_in(stack_position_in), .primary_in(primary_in),
    .nvm_key_in(nvm_key_in), .nvm_guard_level_in(nvm_guard_level_in),
    .extended_write_guard_in(extended_write_guard_in), .target_data_in(target_data_in),
    .target_count_in(target_count_in), .target_valid_in(target_valid_in),
    .resp_toggle_out(resp_toggle_out), .resp_out(resp_out), .target_read_out(target_read_out),
    .target_command_code_out(target_command_code_out),
    .target_phase_number_out(target_phase_number_out),
    .target_page_number_out(target_page_number_out), .write_pass_out(write_pass_out),
    .store_go_out(store_go_out), .key_to_store_out(key_to_store_out),
    .write_guard_level_out(write_guard_level_out), .invalid_command_out(invalid_command_out),
    .invalid_data_out(invalid_data_out), .alert_out(alert_out));

  pmbus_host_model u_host (.link_clk_in(link_clk), .rstn_in(rstn_in), .go_in(go), .cmd_in(cmd),
    .resp_toggle_in(resp_toggle_out), .req_toggle_out(req_toggle_in), .req_out(req_in),
    .done_out(done));

  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // link clock unrelated in phase to the device clock
  initial
  begin
    link_clk = 1'b0;
    #37;
    forever #80 link_clk = ~link_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // register core: answers one cycle after each fetch pulse
  always @(posedge clk_in)
  begin
    #1;
    target_valid_in = trd;
    trd = target_read_out;
    n_ic += (invalid_command_out === 1'b1);
    n_id += (invalid_data_out === 1'b1);
    n_al += (alert_out === 1'b1);
    n_wp += (write_pass_out === 1'b1);
    n_sg += (store_go_out === 1'b1);
    if (target_read_out === 1'b1)
    begin
      n_tr++;
      `CHECK({target_command_code_out, target_phase_number_out, target_page_number_out}, tfields)
    end
    if (rstn_in === 1'b1 && resp_toggle_out !== resp_last)
    begin
      em = exp_q.pop_front();
      mk = msk_q.pop_front();
      `CHECK(resp_out & mk, em & mk)
    end
    resp_last = resp_toggle_out;
  end

  task automatic do_reset();
    rstn_in = 1'b0;
    repeat (6) @(posedge clk_in);
    #1;
    rstn_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
  endtask

  task automatic xfer(input req_kind_e k, input logic [7:0] c, input logic [3:0] n,
      input logic [31:0] d, input logic [35:0] m, input logic [35:0] e);
    int i;
    exp_q.push_back(e);
    msk_q.push_back(m);
    cmd = '{kind: k, code: c, count: n, data: d};
    go = ~go;
    for (i = 0; i < 400 && done === 1'b1; i++)
      @(posedge clk_in);
    for (i = i; i < 400 && done !== 1'b1; i++)
      @(posedge clk_in);
    if (i >= 400)
    begin
      failures++;
      stop_test();
    end
    #1;
  endtask

  // a negative figure leaves that count unchecked
  task automatic flags(input int ic, input int id, input int wp, input int sg);
    if (ic >= 0) `CHECK(n_ic, ic)
    if (id >= 0) `CHECK(n_id, id)
    if (wp >= 0) `CHECK(n_wp, wp)
    if (sg >= 0) `CHECK(n_sg, sg)
    `CHECK(n_al, n_ic + n_id)
    n_ic = 0;
    n_id = 0;
    n_al = 0;
    n_wp = 0;
    n_sg = 0;
  endtask

  logic [15:0] ind_tab [7] = '{16'h0200, 16'hFFFF, 16'hFF00, 16'h02FF, 16'h0205, 16'h0100, 16'h0105};
  logic [7:0] lv [6] = '{WG_OPEN, WG_CTRL, WG_OP, WG_STORE, WG_VOUT_HARD, WG_ALL_HARD};
  logic [4:0] okt [6] = '{5'b11111, 5'b11101, 5'b10001, 5'b00001, 5'b00100, 5'b00000};
  logic [7:0] cmds [4] = '{CMD_OPERATION, CMD_ON_OFF_CONFIG, CMD_VOUT_COMMAND, 8'h30};
  logic [7:0] stat [3] = '{KEY_STAT_1, KEY_STAT_2, KEY_STAT_MAX};

  initial
  begin
    {go, trd, resp_last, target_valid_in, extended_write_guard_in} = '0;
    {cmd, tfields, target_data_in, nvm_key_in, nvm_guard_level_in} = '0;
    {failures, samples_checked, n_ic, n_id, n_al, n_wp, n_sg, n_tr} = '0;
    stack_position_in = 2'h2;
    primary_in = 1'b1;
    target_count_in = 3'h4;
    seed = 32'd81492;
    // a real falling edge, so the host model's reset branch runs too
    rstn_in = 1'b1;
    #1;
    do_reset();
    `CHECK(write_guard_level_out, WG_OPEN)
    for (int i = 0; i < 7; i++)
    begin
      seed = lfsr(seed);
      target_data_in = seed;
      primary_in = (i != 6);
      tfields = {seed[31:24], ind_tab[i]};
      xfer(KIND_CALL, CMD_INDIRECT_PHASE_READ, 4'h3, {8'h00, tfields}, (i < 4) ? M_ALL : M_ACK,
        {i < 4, target_count_in, seed});
    end
    flags(2, 0, 0, 0);
    `CHECK(n_tr, 4)
    $display("test indirect read finished");
    for (int i = 0; i < 6; i++)
    begin
      if (i == 5)
        do_reset();
      xfer(KIND_WRITE, CMD_WRITE_GUARD_LEVEL, 4'h1, {24'h0, lv[i]}, M_ACK, A1);
      `CHECK(write_guard_level_out, lv[i])
      for (int j = 0; j < 4; j++)
      begin
        seed = lfsr(seed);
        xfer(KIND_WRITE, cmds[j], 4'h1, seed, M_ACK, {okt[i][4-j], 35'h0});
      end
      xfer(KIND_SEND, CMD_STORE_USER, 4'h0, 32'h0, M_ACK, {okt[i][0], 35'h0});
      xfer(KIND_READ, CMD_WRITE_GUARD_LEVEL, 4'h1, 32'h0, M_B3, {9'h120, 19'h0, lv[i]});
      flags(0, 5 - $countones(okt[i]), $countones(okt[i][4:1]), okt[i][0]);
    end
    xfer(KIND_WRITE, CMD_WRITE_GUARD_LEVEL, 4'h1, 32'h0, M_ACK, 36'h0);
    `CHECK(write_guard_level_out, WG_ALL_HARD)
    do_reset();
    xfer(KIND_WRITE, CMD_WRITE_GUARD_LEVEL, 4'h1, 32'h55, M_ACK, 36'h0);
    `CHECK(write_guard_level_out, WG_OPEN)
    flags(0, 2, 0, 0);
    $display("test guard levels finished");
    xfer(KIND_READ, CMD_NVM_LOCK_KEY, 4'h3, 32'h0, M_B3, A1);
    key = seed | 32'h1;
    xfer(KIND_WRITE, CMD_NVM_LOCK_KEY, 4'h4, key, M_ACK, A1);
    `CHECK(key_to_store_out, key)
    xfer(KIND_WRITE, CMD_EXTENDED_WRITE_GUARD, 4'h1, 32'h1, M_ACK, A1);
    flags(0, 0, -1, 0);
    nvm_key_in = key;
    extended_write_guard_in = 8'h01;
    do_reset();
    xfer(KIND_READ, CMD_NVM_LOCK_KEY, 4'h3, 32'h0, M_B3, {A1[35:8], KEY_STAT_0});
    xfer(KIND_WRITE, CMD_EXTENDED_WRITE_GUARD, 4'h1, 32'h0, M_ACK, 36'h0);
    xfer(KIND_SEND, CMD_STORE_USER, 4'h0, 32'h0, M_ACK, 36'h0);
    extended_write_guard_in = 8'h00;
    xfer(KIND_SEND, CMD_STORE_USER, 4'h0, 32'h0, M_ACK, A1);
    flags(0, 2, -1, 1);
    for (int j = 0; j < 3; j++)
    begin
      xfer(KIND_WRITE, CMD_NVM_LOCK_KEY, 4'(2 * j + 2), key ^ 32'h100, M_ACK, A1);
      xfer(KIND_READ, CMD_NVM_LOCK_KEY, 4'h3, 32'h0, M_B3, {A1[35:8], stat[j]});
    end
    flags(0, -1, -1, 0);
    xfer(KIND_WRITE, CMD_NVM_LOCK_KEY, 4'h4, key, M_ACK, 36'h0);
    flags(0, 1, -1, 0);
    do_reset();
    xfer(KIND_READ, CMD_NVM_LOCK_KEY, 4'h3, 32'h0, M_B3, {A1[35:8], KEY_STAT_0});
    xfer(KIND_WRITE, CMD_NVM_LOCK_KEY, 4'h4, key, M_ACK, A1);
    xfer(KIND_WRITE, CMD_NVM_LOCK_KEY, 4'h4, KEY_ZERO, M_ACK, A1);
    `CHECK(key_to_store_out, KEY_ZERO)
    xfer(KIND_WRITE, CMD_EXTENDED_WRITE_GUARD, 4'h1, 32'h0, M_ACK, A1);
    xfer(KIND_SEND, CMD_RESTORE_USER, 4'h0, 32'h0, M_ACK, A1);
    xfer(KIND_READ, CMD_NVM_LOCK_KEY, 4'h3, 32'h0, M_B3, {A1[35:8], KEY_STAT_0});
    flags(0, 0, -1, 0);
    $display("test lock key finished");
    stop_test();
  end
endmodule // pmbus_access_guard_test
